// *** cpr_cell_port.sv ***
// Cell port: slave receive cell signalling, tx idle cells, MII status, DMA module number
`timescale 1ns/10ps
`include "cpr_params.svh"
module cpr_cell_port
   import cpr_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic link_clk,
   // Core side: one receive cell to hand to the external master
   input wire logic cell_wr_valid,
   output logic cell_wr_ready,
   input wire cpr_pkg::cpr_octet_t cell_wr_data,
   // Core side: transmit octets
   input wire logic tx_wr_valid,
   output logic tx_wr_ready,
   input wire cpr_pkg::cpr_octet_t tx_wr_data,
   // Link, slave receive
   input wire logic rx_enable_n,
   output cpr_pkg::cpr_octet_t rx_data_out,
   output logic rx_data_oe,
   output logic rx_start_of_cell,
   output logic rx_cell_available,
   // Link, transmit octets
   output cpr_pkg::cpr_octet_t tx_data_out,
   output logic tx_start_of_cell,
   // Master-mode polled availability and MII status pins
   input wire logic rx_cell_avail_in,
   input wire logic polled_cell_available_line_zero,
   input wire logic mii_rx_dv,
   input wire logic mii_rx_er,
   input wire logic mii_crs,
   output logic phy_cell_ready,
   output logic polled_cell_ready,
   output logic mii_broken_header,
   output logic mii_rx_error,
   // Serial DMA module number
   input wire logic serial_dma_unit_active,
   input wire logic [4:0] serial_dma_unit_code,
   input wire logic serial_dma_unit_rx,
   input wire logic serial_dma_unit_error,
   output cpr_pkg::cpr_modnum_t serial_dma_module_number,
   output cpr_pkg::cpr_modnum_t serial_dma_error_module
);
   import cpr_pkg::*;

   // ---------------- Core clock: cell byte counter into the buffer ----------------
   cpr_count_t fill_cnt_q;
   logic buf_in_ready;
   logic fill_last;
   assign fill_last = (fill_cnt_q == `CPR_CELL_LAST);
   assign buf_in_ready = cell_wr_ready;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         fill_cnt_q <= 6'd0;
      end else if (cell_wr_valid && buf_in_ready) begin
         fill_cnt_q <= fill_last ? 6'd0 : fill_cnt_q + 6'd1;
      end
   end

   // Cell bytes cross one at a time by a req/ack handshake
   cpr_octet_t xfer_data_q;
   logic xfer_last_q;
   logic xfer_req_q;
   logic ack_s1_q, ack_s2_q, ack_s3_q;
   logic link_ack_q;
   logic xfer_req_d;
   assign xfer_req_d = xfer_req_q ^ (cell_wr_valid && buf_in_ready);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         xfer_req_q <= 1'b0;
         xfer_data_q <= 8'h00;
         xfer_last_q <= 1'b0;
      end else if (cell_wr_valid && buf_in_ready) begin
         xfer_req_q <= ~xfer_req_q;
         xfer_data_q <= cell_wr_data;
         xfer_last_q <= fill_last;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         ack_s3_q <= 1'b0;
         cell_wr_ready <= 1'b0;
      end else begin
         ack_s1_q <= link_ack_q;
         ack_s2_q <= ack_s1_q;
         ack_s3_q <= ack_s2_q;
         // Next-cycle view of the idle handshake, so ready leaves a flop
         cell_wr_ready <= (xfer_req_d == ack_s2_q) && (ack_s1_q == ack_s2_q);
      end
   end

   // ---------------- Link clock: receive side ----------------
   logic req_s1_q, req_s2_q, req_s3_q;
   logic lk_in_valid, lk_in_ready;
   logic lk_out_valid, lk_out_ready, lk_out_last;
   cpr_octet_t lk_out_data;
   logic en_s1_q, en_s2_q, en_s3_q;
   cpr_rx_state_t rx_state_q;
   cpr_count_t stored_q;
   cpr_count_t sent_q;
   logic cell_ready;

   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         req_s3_q <= 1'b0;
      end else begin
         req_s1_q <= xfer_req_q;
         req_s2_q <= req_s1_q;
         req_s3_q <= req_s2_q;
      end
   end

   assign lk_in_valid = (req_s2_q == req_s3_q) && (req_s3_q != link_ack_q);

   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         link_ack_q <= 1'b0;
      end else if (lk_in_valid && lk_in_ready) begin
         link_ack_q <= req_s3_q;
      end
   end

   cpr_skid_buf u_buf (
      .clk(link_clk),
      .rst(sys_rst),
      .in_valid(lk_in_valid),
      .in_ready(lk_in_ready),
      .in_data(xfer_data_q),
      .in_last(xfer_last_q),
      .out_valid(lk_out_valid),
      .out_ready(lk_out_ready),
      .out_data(lk_out_data),
      .out_last(lk_out_last)
   );

   // Whole cell gathered in flops first, so the master can pull at line rate
   cpr_octet_t cell_mem_q [0:52];
   logic send_fire;
   assign lk_out_ready = (rx_state_q == CPR_RX_WAIT) && (stored_q != `CPR_CELL_BYTES);

   always_ff @(posedge link_clk) begin
      if (lk_out_ready && lk_out_valid) cell_mem_q[stored_q] <= lk_out_data;
   end

   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stored_q <= 6'd0;
      end else if (lk_out_ready && lk_out_valid) begin
         stored_q <= lk_out_last ? `CPR_CELL_BYTES : stored_q + 6'd1;
      end else if (rx_state_q == CPR_RX_DONE) begin
         stored_q <= 6'd0;
      end
   end

   assign cell_ready = (stored_q == `CPR_CELL_BYTES);

   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         en_s1_q <= 1'b1;
         en_s2_q <= 1'b1;
         en_s3_q <= 1'b1;
      end else begin
         en_s1_q <= rx_enable_n;
         en_s2_q <= en_s1_q;
         en_s3_q <= en_s2_q;
      end
   end

   logic enable_seen;
   assign enable_seen = !en_s2_q && !en_s3_q;
   assign send_fire = (rx_state_q == CPR_RX_SEND) && enable_seen;

   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_state_q <= CPR_RX_WAIT;
         sent_q <= 6'd0;
      end else begin
         case (rx_state_q)
            CPR_RX_WAIT: begin
               if (cell_ready) rx_state_q <= CPR_RX_SEND;
               sent_q <= 6'd0;
            end
            CPR_RX_SEND: begin
               if (send_fire) begin
                  sent_q <= sent_q + 6'd1;
                  if (sent_q == `CPR_CELL_LAST) rx_state_q <= CPR_RX_DONE;
               end
            end
            CPR_RX_DONE: rx_state_q <= CPR_RX_WAIT;
            default: rx_state_q <= CPR_RX_WAIT;
         endcase
      end
   end

   // Data, oe and start of cell driven only in the cycle after enable was seen; cell available is not gated by enable
   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_data_out <= 8'h00;
         rx_data_oe <= 1'b0;
         rx_start_of_cell <= 1'b0;
         rx_cell_available <= 1'b0;
      end else begin
         rx_data_oe <= send_fire;
         if (send_fire) rx_data_out <= cell_mem_q[sent_q];
         rx_start_of_cell <= send_fire && (sent_q == 6'd0);
         rx_cell_available <= cell_ready && (sent_q == 6'd0) && (rx_state_q != CPR_RX_DONE);
      end
   end

   // ---------------- Link clock: transmit octets with idle fill ----------------
   cpr_count_t tx_pos_q;
   logic tx_idle_q;
   logic tx_take;
   // Core-to-link transmit path kept on link clock via the same handshake scheme
   logic txr_s1_q, txr_s2_q, txr_s3_q, tx_ack_q;
   logic tx_req_q, txa_s1_q, txa_s2_q, txa_s3_q;
   cpr_octet_t tx_hold_q;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_req_q <= 1'b0;
         tx_hold_q <= 8'h00;
         txa_s1_q <= 1'b0;
         txa_s2_q <= 1'b0;
         txa_s3_q <= 1'b0;
         tx_wr_ready <= 1'b0;
      end else begin
         txa_s1_q <= tx_ack_q;
         txa_s2_q <= txa_s1_q;
         txa_s3_q <= txa_s2_q;
         tx_wr_ready <= ((tx_req_q ^ (tx_wr_valid && tx_wr_ready)) == txa_s2_q) && (txa_s1_q == txa_s2_q);
         if (tx_wr_valid && tx_wr_ready) begin
            tx_req_q <= ~tx_req_q;
            tx_hold_q <= tx_wr_data;
         end
      end
   end

   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         txr_s1_q <= 1'b0;
         txr_s2_q <= 1'b0;
         txr_s3_q <= 1'b0;
      end else begin
         txr_s1_q <= tx_req_q;
         txr_s2_q <= txr_s1_q;
         txr_s3_q <= txr_s2_q;
      end
   end

   // Payload starts a cell only with all 53 bytes held, so a slow core never tears a cell
   cpr_octet_t tx_mem_q [0:52];
   cpr_count_t tx_fill_q;
   logic tx_send;
   assign tx_take = (txr_s2_q == txr_s3_q) && (txr_s3_q != tx_ack_q) && tx_idle_q && (tx_fill_q != `CPR_CELL_BYTES);
   assign tx_send = (tx_pos_q == 6'd0) ? (tx_fill_q == `CPR_CELL_BYTES) : !tx_idle_q;

   always_ff @(posedge link_clk) begin
      if (tx_take) tx_mem_q[tx_fill_q] <= tx_hold_q;
   end

   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_pos_q <= 6'd0;
         tx_idle_q <= 1'b1;
         tx_ack_q <= 1'b0;
         tx_fill_q <= 6'd0;
         tx_data_out <= 8'h00;
         tx_start_of_cell <= 1'b0;
      end else begin
         tx_start_of_cell <= (tx_pos_q == 6'd0);
         tx_pos_q <= (tx_pos_q == `CPR_CELL_LAST) ? 6'd0 : tx_pos_q + 6'd1;
         if (tx_pos_q == 6'd0) tx_idle_q <= !tx_send;
         if (tx_take) begin
            tx_ack_q <= txr_s3_q;
            tx_fill_q <= tx_fill_q + 6'd1;
         end else if (!tx_idle_q && tx_pos_q == `CPR_CELL_LAST) begin
            tx_fill_q <= 6'd0;
         end
         if (tx_send) tx_data_out <= tx_mem_q[tx_pos_q];
         else tx_data_out <= (tx_pos_q == `CPR_IDLE_HDR3_POS) ? `CPR_IDLE_HDR3 :
            (tx_pos_q < 6'd5) ? `CPR_IDLE_HDR0 : `CPR_IDLE_PAYLOAD;
      end
   end

   // ---------------- Master-mode and MII status inputs (pins, three flops) ----------------
   logic [4:0] st_s1_q, st_s2_q, st_s3_q;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_s1_q <= 5'h00;
         st_s2_q <= 5'h00;
         st_s3_q <= 5'h00;
      end else begin
         st_s1_q <= {rx_cell_avail_in, polled_cell_available_line_zero, mii_rx_dv, mii_rx_er, mii_crs};
         st_s2_q <= st_s1_q;
         st_s3_q <= st_s2_q;
      end
   end

   logic [4:0] st_stable;
   assign st_stable = ~(st_s2_q ^ st_s3_q);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         phy_cell_ready <= 1'b0;
         polled_cell_ready <= 1'b0;
         mii_broken_header <= 1'b0;
         mii_rx_error <= 1'b0;
      end else begin
         if (st_stable[4]) phy_cell_ready <= st_s3_q[4];
         if (st_stable[3]) polled_cell_ready <= st_s3_q[3];
         if (st_stable[0] && st_stable[2]) mii_broken_header <= st_s3_q[0] && !st_s3_q[2];
         if (st_stable[1]) mii_rx_error <= st_s3_q[1];
      end
   end

   // ---------------- Serial DMA module number ----------------
   cpr_modnum_t modnum;
   always_comb begin
      modnum = `CPR_MOD_RESET;
      modnum[`CPR_MOD_CODE_MSB:`CPR_MOD_CODE_LSB] = serial_dma_unit_code;
      modnum[`CPR_MOD_DIR_BIT] = serial_dma_unit_rx;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         serial_dma_module_number <= `CPR_MOD_RESET;
         serial_dma_error_module <= `CPR_MOD_RESET;
      end else begin
         serial_dma_module_number <= serial_dma_unit_active ? modnum : `CPR_MOD_RESET;
         if (serial_dma_unit_active && serial_dma_unit_error) serial_dma_error_module <= modnum;
      end
   end

endmodule : cpr_cell_port

// *** cpr_cell_port_checker.sv ***
// Assertion checker for the cell port block
`timescale 1ns/10ps
module cpr_cell_port_checker (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic link_clk,
   input wire logic rx_enable_n,
   input wire logic rx_data_oe,
   input wire logic rx_start_of_cell,
   input wire logic rx_cell_available,
   input wire logic tx_start_of_cell,
   input wire logic rx_cell_avail_in,
   input wire logic polled_cell_available_line_zero,
   input wire logic mii_rx_dv,
   input wire logic mii_rx_er,
   input wire logic mii_crs,
   input wire logic phy_cell_ready,
   input wire logic polled_cell_ready,
   input wire logic mii_broken_header,
   input wire logic mii_rx_error,
   input wire logic serial_dma_unit_active,
   input wire logic [4:0] serial_dma_unit_code,
   input wire logic serial_dma_unit_rx,
   input wire logic serial_dma_unit_error,
   input wire cpr_pkg::cpr_modnum_t serial_dma_module_number,
   input wire cpr_pkg::cpr_modnum_t serial_dma_error_module
);
   import cpr_pkg::*;
   cpr_count_t nbyte_q;
   // Bytes of the receive cell seen so far on the link
   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) nbyte_q <= 6'h00;
      else if (rx_start_of_cell) nbyte_q <= 6'h01;
      else if (rx_data_oe) nbyte_q <= nbyte_q + 6'h01;
   end
   // Six cycles cover the three-flop deglitch plus the output register
   broken_header_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (mii_crs && !mii_rx_dv) [*6] |-> mii_broken_header) else $error("broken header flag missing");
   rx_error_a: assert property (@(posedge mclk) disable iff (sys_rst)
      mii_rx_er [*6] |-> mii_rx_error) else $error("receive error flag missing");
   phy_ready_a: assert property (@(posedge mclk) disable iff (sys_rst)
      rx_cell_avail_in [*6] |-> phy_cell_ready) else $error("phy cell ready missing");
   polled_ready_a: assert property (@(posedge mclk) disable iff (sys_rst)
      polled_cell_available_line_zero [*6] |-> polled_cell_ready) else $error("polled ready missing");
   module_number_a: assert property (@(posedge mclk) disable iff (sys_rst)
      serial_dma_unit_active |=> serial_dma_module_number == {$past(serial_dma_unit_rx), $past(serial_dma_unit_code)})
      else $error("module number wrong");
   error_capture_a: assert property (@(posedge mclk) disable iff (sys_rst)
      serial_dma_unit_active && serial_dma_unit_error |=>
      serial_dma_error_module == {$past(serial_dma_unit_rx), $past(serial_dma_unit_code)}) else $error("error capture wrong");
   error_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !(serial_dma_unit_active && serial_dma_unit_error) |=> $stable(serial_dma_error_module))
      else $error("error record changed");
   cell_start_a: assert property (@(posedge link_clk) disable iff (sys_rst)
      rx_start_of_cell |-> rx_data_oe && (nbyte_q == 6'h00 || nbyte_q == 6'h35)) else $error("start of cell misplaced");
   drive_enable_a: assert property (@(posedge link_clk) disable iff (sys_rst)
      rx_data_oe |-> !$past(rx_enable_n)) else $error("data driven without enable");
   clav_drop_a: assert property (@(posedge link_clk) disable iff (sys_rst)
      rx_data_oe && nbyte_q == 6'h34 |=> !rx_cell_available) else $error("cell available after last byte");
   tx_cell_len_a: assert property (@(posedge link_clk) disable iff (sys_rst)
      tx_start_of_cell |-> ##53 tx_start_of_cell) else $error("tx cell length wrong");
endmodule : cpr_cell_port_checker
bind cpr_cell_port cpr_cell_port_checker i_chk (.*);

// *** cpr_cell_port_test.sv ***
// Self-checking bench for the cell port block
`timescale 1ns/10ps
module cpr_cell_port_test;
   import cpr_pkg::*;
   typedef struct packed {
      logic [4:0] pins;
      logic [2:0] dma;
      logic [4:0] code;
      logic [3:0] fl;
      cpr_modnum_t mod;
      cpr_modnum_t emod;
   } cpr_row_t;
   logic mclk, sys_rst, link_clk, hold, soc_ok, sent;
   logic cell_wr_valid, cell_wr_ready, tx_wr_valid, tx_wr_ready;
   cpr_octet_t cell_wr_data, tx_wr_data, rx_data_out, tx_data_out;
   logic rx_enable_n, rx_data_oe, rx_start_of_cell, rx_cell_available, tx_start_of_cell;
   logic rx_cell_avail_in, polled_cell_available_line_zero, mii_rx_dv, mii_rx_er, mii_crs;
   logic phy_cell_ready, polled_cell_ready, mii_broken_header, mii_rx_error;
   logic serial_dma_unit_active, serial_dma_unit_rx, serial_dma_unit_error;
   logic [4:0] serial_dma_unit_code;
   cpr_modnum_t serial_dma_module_number, serial_dma_error_module;
   int miscompares, checks_done, got, n;
   cpr_row_t rows [5];
   cpr_octet_t cap [0:52];
   cpr_cell_port i_dut (.*);
   cpr_utopia_master i_master (.*);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Link edges land inside the four-cycle reset
   initial begin
      link_clk = 1'b0;
      #1;
      forever begin
         link_clk = ~link_clk;
         #16;
      end
   end
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
      checks_done++;
      if (seen !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, seen);
         miscompares++;
      end
   endtask : chk
   task automatic finish_test();
      $display("Checks %0d, errors %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   task automatic tmo(input string nm);
      chk(nm, 8'h01, 8'h00);
      finish_test();
   endtask : tmo
   // Valid drops for a cycle after each byte so a byte is never taken twice
   task automatic push(input logic tx, input cpr_octet_t d);
      int k;
      k = 0;
      if (tx) tx_wr_data = d;
      else cell_wr_data = d;
      tx_wr_valid = tx;
      cell_wr_valid = !tx;
      while ((tx ? tx_wr_ready : cell_wr_ready) !== 1'b1) begin
         @(negedge mclk);
         if (++k > 300) tmo("ready wait");
      end
      @(negedge mclk);
      {tx_wr_valid, cell_wr_valid} = 2'h0;
      @(negedge mclk);
   endtask : push
   initial begin
      {sys_rst, hold, sent} = 3'h6;
      {cell_wr_valid, tx_wr_valid, rx_cell_avail_in, polled_cell_available_line_zero} = 4'h0;
      {mii_rx_dv, mii_rx_er, mii_crs, serial_dma_unit_active, serial_dma_unit_rx, serial_dma_unit_error} = 6'h00;
      {cell_wr_data, tx_wr_data, serial_dma_unit_code} = 21'h0;
      {miscompares, checks_done} = 64'h0;
      rows[0] = {5'h10, 3'h4, 5'h05, 4'h8, 6'h05, 6'h00};
      rows[1] = {5'h1e, 3'h7, 5'h1f, 4'h6, 6'h3f, 6'h3f};
      rows[2] = {5'h09, 3'h2, 5'h0a, 4'h1, 6'h00, 6'h3f};
      rows[3] = {5'h07, 3'h5, 5'h10, 4'h7, 6'h10, 6'h10};
      rows[4] = {5'h14, 3'h1, 5'h03, 4'hc, 6'h00, 6'h10};
      repeat (4) @(negedge mclk);
      sys_rst = 1'b0;
      foreach (rows[i]) begin
         {mii_crs, mii_rx_dv, mii_rx_er, rx_cell_avail_in, polled_cell_available_line_zero} = rows[i].pins;
         {serial_dma_unit_active, serial_dma_unit_rx, serial_dma_unit_error} = rows[i].dma;
         serial_dma_unit_code = rows[i].code;
         repeat (8) @(negedge mclk);
         chk("status flags", {4'h0, rows[i].fl}, {4'h0, mii_broken_header, mii_rx_error, phy_cell_ready,
            polled_cell_ready});
         chk("module number", {2'h0, rows[i].mod}, {2'h0, serial_dma_module_number});
         chk("error module", {2'h0, rows[i].emod}, {2'h0, serial_dma_error_module});
      end
      // Second cell loads behind a held master, then is pulled late
      for (int c = 0; c < 2; c++) begin
         hold = (c == 1);
         for (int i = 0; i < 53; i++) begin
            if (i == 52) begin
               repeat (40) @(negedge mclk);
               chk("early cell available", 8'h00, {7'h0, rx_cell_available});
            end
            push(1'b0, 8'(c * 64 + i));
         end
         repeat (c * 50) @(negedge mclk);
         hold = 1'b0;
         n = 0;
         while (got != 53) begin
            @(negedge mclk);
            if (++n > 3000) tmo("cell transfer");
         end
         chk("start of cell", 8'h01, {7'h0, soc_ok});
         for (int i = 0; i < 53; i++) chk("cell byte", 8'(c * 64 + i), i_master.mem[i]);
         chk("cell available after", 8'h00, {7'h0, rx_cell_available});
      end
      fork
         for (int i = 0; i < 53; i++) push(1'b1, 8'(8'h80 + i));
         begin
            @(negedge link_clk);
            for (int c = 0; c < 8; c++) begin
               n = 0;
               while (tx_start_of_cell !== 1'b1) begin
                  @(negedge link_clk);
                  if (++n > 120) tmo("tx cell start");
               end
               for (int j = 0; j < 53; j++) begin
                  cap[j] = tx_data_out;
                  @(negedge link_clk);
               end
               if (cap[0] === 8'h80) sent = 1'b1;
               for (int j = 0; j < 53; j++) begin
                  if (cap[0] === 8'h80) chk("tx payload", 8'(8'h80 + j), cap[j]);
                  else chk("tx idle", (j == 3) ? 8'h01 : (j < 5) ? 8'h00 : 8'h6a, cap[j]);
               end
            end
         end
      join
      chk("tx payload sent", 8'h01, {7'h0, sent});
      @(negedge mclk);
      sys_rst = 1'b1;
      repeat (4) @(negedge mclk);
      chk("reset outputs", 8'h00, {rx_data_oe, rx_start_of_cell, rx_cell_available, tx_start_of_cell,
         mii_broken_header, mii_rx_error, phy_cell_ready, polled_cell_ready});
      chk("reset error module", 8'h00, {2'h0, serial_dma_error_module});
      sys_rst = 1'b0;
      repeat (10) @(negedge mclk);
      finish_test();
   end
endmodule : cpr_cell_port_test

// *** cpr_params.svh ***
// Constants for the cell port receive/status block
`ifndef CPR_PARAMS_SVH
`define CPR_PARAMS_SVH
`define CPR_CELL_BYTES 6'd53
`define CPR_CELL_LAST 6'd52
`define CPR_IDLE_HDR0 8'h00
`define CPR_IDLE_HDR3 8'h01
`define CPR_IDLE_PAYLOAD 8'h6a
`define CPR_IDLE_HDR3_POS 6'd3
`define CPR_MOD_CODE_LSB 0
`define CPR_MOD_CODE_MSB 4
`define CPR_MOD_DIR_BIT 5
`define CPR_MOD_RESET 6'h00
`endif

// *** cpr_pkg.sv ***
// Types for the cell port receive/status block
package cpr_pkg;
   typedef logic [7:0] cpr_octet_t;
   typedef logic [5:0] cpr_count_t;
   typedef logic [5:0] cpr_modnum_t;
   typedef enum logic [2:0] {
      CPR_RX_WAIT = 3'b001,
      CPR_RX_SEND = 3'b010,
      CPR_RX_DONE = 3'b100
   } cpr_rx_state_t;
endpackage : cpr_pkg

// *** cpr_skid_buf.sv ***
// Two-entry valid/ready buffer on the link clock
`timescale 1ns/10ps
module cpr_skid_buf
   import cpr_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire cpr_pkg::cpr_octet_t in_data,
   input wire logic in_last,
   output logic out_valid,
   input wire logic out_ready,
   output cpr_pkg::cpr_octet_t out_data,
   output logic out_last
);
   logic [8:0] mem_q [0:1];
   logic wr_ptr_q;
   logic rd_ptr_q;
   logic [1:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != 2'd2);
   assign out_valid = (cnt_q != 2'd0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_q[rd_ptr_q][7:0];
   assign out_last = mem_q[rd_ptr_q][8];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_q[0] <= 9'h000;
         mem_q[1] <= 9'h000;
      end else if (push) begin
         mem_q[wr_ptr_q] <= {in_last, in_data};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         cnt_q <= 2'd0;
      end else begin
         if (push) wr_ptr_q <= ~wr_ptr_q;
         if (pop) rd_ptr_q <= ~rd_ptr_q;
         case ({push, pop})
            2'b10: cnt_q <= cnt_q + 2'd1;
            2'b01: cnt_q <= cnt_q - 2'd1;
            default: cnt_q <= cnt_q;
         endcase
      end
   end
endmodule : cpr_skid_buf

// *** cpr_utopia_master.sv ***
// Behavioural link master that pulls receive cells from the slave port
`timescale 1ns/10ps
module cpr_utopia_master (
   input wire logic link_clk,
   input wire logic sys_rst,
   input wire logic hold,
   input wire logic rx_cell_available,
   input wire logic rx_data_oe,
   input wire logic rx_start_of_cell,
   input wire cpr_pkg::cpr_octet_t rx_data_out,
   output logic rx_enable_n,
   output int got,
   output logic soc_ok
);
   import cpr_pkg::*;
   cpr_octet_t mem [0:52];
   always @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_enable_n <= 1'b1;
         got <= 0;
         soc_ok <= 1'b1;
      end else if (hold) begin
         got <= 0;
         soc_ok <= 1'b1;
      end else begin
         // Enable spans one whole cell so the slave never stops mid-cell
         if (rx_enable_n && rx_cell_available && got == 0) rx_enable_n <= 1'b0;
         if (rx_data_oe && got < 53) begin
            mem[got] <= rx_data_out;
            if (rx_start_of_cell != (got == 0)) soc_ok <= 1'b0;
            got <= got + 1;
            if (got == 52) rx_enable_n <= 1'b1;
         end
      end
   end
endmodule : cpr_utopia_master
